//--- rtl/io_map_pkg.sv
// constants for the drive input/output function mapper
// Notes on behaviour
// - eight input selectors with fixed function codes
// - one input function per terminal at most
// - reset presets: stop, limits, reference assigned
// - probe one allowed only on input 7
// - probe two allowed only on input 6
// - active probe input triggers its capture channel
// - stop input ramps down, then disables power
// - limit input alerts, decelerates with own ramp
// - gain increase raises gain while active
// - four output selectors, codes 01 to 09
// - output codes 10 to 18, 17 unused
// - codes 30 to 33 copy software word bits
// - function effect depends on operating mode
// - ready output whenever not in fault
// - powered output only in operation enabled
// - limits work even under exclusive access
package io_map_pkg;
  localparam logic [7:0] FN_NONE = 8'h00;
  localparam logic [7:0] FN_GAIN = 8'h03;
  localparam logic [7:0] FN_PROBE1 = 8'h1c;
  localparam logic [7:0] FN_PROBE2 = 8'h1d;
  localparam logic [7:0] FN_STOP = 8'h21;
  localparam logic [7:0] FN_NEGLIM = 8'h22;
  localparam logic [7:0] FN_POSLIM = 8'h23;
  localparam logic [7:0] FN_REFSW = 8'h24;
  localparam int PROBE1_TERM = 6;
  localparam int PROBE2_TERM = 5;
  localparam logic [7:0] OF_READY = 8'h01;
  localparam logic [7:0] OF_POWERED = 8'h02;
  localparam logic [7:0] OF_ZSPEED = 8'h03;
  localparam logic [7:0] OF_SPEED = 8'h04;
  localparam logic [7:0] OF_MOVED = 8'h05;
  localparam logic [7:0] OF_TORQUE = 8'h06;
  localparam logic [7:0] OF_ERROR = 8'h07;
  localparam logic [7:0] OF_BRAKE = 8'h08;
  localparam logic [7:0] OF_HOMED = 8'h09;
  localparam logic [7:0] OF_OVERLOAD = 8'h10;
  localparam logic [7:0] OF_ALERT = 8'h11;
  localparam logic [7:0] OF_OVERFLOW = 8'h12;
  localparam logic [7:0] OF_SOFTNEG = 8'h13;
  localparam logic [7:0] OF_SOFTPOS = 8'h14;
  localparam logic [7:0] OF_CMDDONE = 8'h15;
  localparam logic [7:0] OF_CAP1 = 8'h16;
  localparam logic [7:0] OF_CAP2 = 8'h18;
  localparam logic [7:0] OF_SW0 = 8'h30;
  localparam logic [7:0] OF_SW3 = 8'h33;
  // drive operating states as reported by the state machine
  typedef enum logic [3:0] {
    ST_START = 4'h1, ST_NOTREADY = 4'h2, ST_DISABLED = 4'h3,
    ST_READY = 4'h4, ST_SWITCHED = 4'h5, ST_OPENABLED = 4'h6,
    ST_QSTOP = 4'h7, ST_FAULTREACT = 4'h8, ST_FAULT = 4'h9
  } drive_state_t;
  localparam logic [1:0] MODE_POSITION = 2'h0;
  localparam logic [1:0] MODE_TORQUE = 2'h2;
  localparam logic [7:0] ADDR_INSEL = 8'h00;
  localparam logic [7:0] ADDR_OUTSEL = 8'h20;
  localparam logic [7:0] ADDR_SWWORD = 8'h30;
  localparam logic [7:0] ADDR_STOPRAMP = 8'h34;
  localparam logic [7:0] ADDR_NEGRAMP = 8'h38;
  localparam logic [7:0] ADDR_POSRAMP = 8'h3c;
  localparam logic [7:0] ADDR_GAIN = 8'h40;
  localparam logic [7:0] ADDR_MODE = 8'h44;
  localparam logic [7:0] ADDR_STATUS = 8'h48;
  localparam int ST_CFGERR = 8;
  localparam logic [63:0] INSEL_RESET = 64'h2123_2224_0000_0000;
  localparam logic [31:0] OUTSEL_RESET = 32'h0000_0001;
  localparam logic [15:0] RAMP_RESET = 16'h0064;
endpackage

//--- rtl/drive_io_function_mapper.sv
// selector-driven mapping of drive functions onto digital inputs and outputs
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module drive_io_function_mapper
  import io_map_pkg::*;
#(
  parameter int NUM_IN = 8,
  parameter int NUM_OUT = 4
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_IN-1:0] digitalInputTerminal,
  input wire logic [3:0] driveState,
  input wire logic exclusiveAccess,
  input wire logic decelDone,
  input wire logic [12:0] statusIn,
  output logic [NUM_OUT-1:0] digitalOutputTerminal,
  output logic [1:0] probeTrigger,
  output logic decelRequest,
  output logic [15:0] decelRamp,
  output logic powerDisable,
  output logic limitAlert,
  output logic gainBoost,
  output logic [15:0] gainValue,
  output logic referenceSwitch
);
  // statusIn order: zero speed, speed reached, move done, torque limit, brake,
  // homed, overload, overflow, soft neg, soft pos, cmd done, cap1, cap2

  ////////////////////////////////////////////////////////////////////////////
  logic [NUM_IN-1:0] diMeta_reg, diSync_reg, diDly_reg;
  logic [7:0] inSel_reg [NUM_IN];
  logic [7:0] outSel_reg [NUM_OUT];
  logic [3:0] swWord_reg;
  logic [15:0] stopRamp_reg, negRamp_reg, posRamp_reg, gain_reg;
  logic [1:0] mode_reg;
  logic cfgErr_reg;
  logic [31:0] rdata_next;
  logic acc, wr, inWr, selOk, mapped;
  logic [2:0] inIdx;
  logic [7:0] code;

  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;
  assign inIdx = paddr[4:2];
  assign inWr = wr && paddr[7:5] == ADDR_INSEL[7:5] && paddr[1:0] == 2'h0;
  assign code = pwdata[7:0];

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      diMeta_reg <= '0;
      diSync_reg <= '0;
      diDly_reg <= '0;
    end
    else
    begin
      diMeta_reg <= digitalInputTerminal;
      diSync_reg <= diMeta_reg;
      diDly_reg <= diSync_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // selector write check: duplicates and misplaced probes are refused
  always_comb
  begin
    selOk = 1'b1;
    for (int j = 0; j < NUM_IN; j++)
    begin
      if (code != FN_NONE && 3'(j) != inIdx && inSel_reg[j] == code)
        selOk = 1'b0;
    end
    if (code == FN_PROBE1 && inIdx != 3'(PROBE1_TERM))
      selOk = 1'b0;
    if (code == FN_PROBE2 && inIdx != 3'(PROBE2_TERM))
      selOk = 1'b0;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++)
    begin : g_insel
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
          inSel_reg[gi] <= INSEL_RESET[gi*8 +: 8];
        else if (inWr && inIdx == 3'(gi) && selOk)
          inSel_reg[gi] <= code;
      end
    end
    for (gi = 0; gi < NUM_OUT; gi++)
    begin : g_outsel
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
          outSel_reg[gi] <= OUTSEL_RESET[gi*8 +: 8];
        else if (wr && paddr == ADDR_OUTSEL + 8'(gi * 4))
          outSel_reg[gi] <= code;
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      swWord_reg <= '0;
      stopRamp_reg <= RAMP_RESET;
      negRamp_reg <= RAMP_RESET;
      posRamp_reg <= RAMP_RESET;
      gain_reg <= '0;
      mode_reg <= MODE_POSITION;
    end
    else if (wr)
    begin
      case (paddr)
        ADDR_SWWORD: swWord_reg <= pwdata[3:0];
        ADDR_STOPRAMP: stopRamp_reg <= pwdata[15:0];
        ADDR_NEGRAMP: negRamp_reg <= pwdata[15:0];
        ADDR_POSRAMP: posRamp_reg <= pwdata[15:0];
        ADDR_GAIN: gain_reg <= pwdata[15:0];
        ADDR_MODE: mode_reg <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // refused selector write sets the error; a new refusal beats the clear
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cfgErr_reg <= 1'b0;
    else if (inWr && !selOk)
      cfgErr_reg <= 1'b1;
    else if (wr && paddr == ADDR_STATUS && pwdata[ST_CFGERR])
      cfgErr_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb: one wait-free access phase; answer prepared in the setup cycle
  always_comb
  begin
    mapped = 1'b1;
    rdata_next = '0;
    if (paddr[7:5] == ADDR_INSEL[7:5])
      rdata_next[7:0] = inSel_reg[paddr[4:2]];
    else if (paddr[7:4] == ADDR_OUTSEL[7:4])
      rdata_next[7:0] = outSel_reg[paddr[3:2]];
    else
    begin
      case (paddr)
        ADDR_SWWORD: rdata_next[3:0] = swWord_reg;
        ADDR_STOPRAMP: rdata_next[15:0] = stopRamp_reg;
        ADDR_NEGRAMP: rdata_next[15:0] = negRamp_reg;
        ADDR_POSRAMP: rdata_next[15:0] = posRamp_reg;
        ADDR_GAIN: rdata_next[15:0] = gain_reg;
        ADDR_MODE: rdata_next[1:0] = mode_reg;
        ADDR_STATUS: rdata_next = {23'h0, cfgErr_reg, diSync_reg};
        default: mapped = 1'b0;
      endcase
    end
    if (paddr[1:0] != 2'h0)
      mapped = 1'b0;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else if (psel && !penable && !pready)
    begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0 : rdata_next;
      pslverr <= !mapped;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input functions: unlisted codes never match, so they stay ignored
  logic fGain, fStop, fNeg, fPos, fRef, p1Now, p1Was, p2Now, p2Was;
  always_comb
  begin
    fGain = 1'b0;
    fStop = 1'b0;
    fNeg = 1'b0;
    fPos = 1'b0;
    fRef = 1'b0;
    for (int j = 0; j < NUM_IN; j++)
    begin
      fGain |= diSync_reg[j] && inSel_reg[j] == FN_GAIN;
      fStop |= diSync_reg[j] && inSel_reg[j] == FN_STOP;
      fNeg |= diSync_reg[j] && inSel_reg[j] == FN_NEGLIM;
      fPos |= diSync_reg[j] && inSel_reg[j] == FN_POSLIM;
      fRef |= diSync_reg[j] && inSel_reg[j] == FN_REFSW;
    end
  end
  assign p1Now = diSync_reg[PROBE1_TERM] && inSel_reg[PROBE1_TERM] == FN_PROBE1;
  assign p1Was = diDly_reg[PROBE1_TERM] && inSel_reg[PROBE1_TERM] == FN_PROBE1;
  assign p2Now = diSync_reg[PROBE2_TERM] && inSel_reg[PROBE2_TERM] == FN_PROBE2;
  assign p2Was = diDly_reg[PROBE2_TERM] && inSel_reg[PROBE2_TERM] == FN_PROBE2;

  // limits stay live under exclusive access; gain boost does not, and
  // torque mode has no gain switching so the request is dropped there
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      probeTrigger <= '0;
      decelRequest <= 1'b0;
      decelRamp <= '0;
      powerDisable <= 1'b0;
      limitAlert <= 1'b0;
      gainBoost <= 1'b0;
      gainValue <= '0;
      referenceSwitch <= 1'b0;
    end
    else
    begin
      probeTrigger <= {p2Now && !p2Was, p1Now && !p1Was};
      limitAlert <= fNeg | fPos;
      decelRequest <= fNeg | fPos | fStop;
      if (fNeg)
        decelRamp <= negRamp_reg;
      else if (fPos)
        decelRamp <= posRamp_reg;
      else if (fStop)
        decelRamp <= stopRamp_reg;
      powerDisable <= fStop && (powerDisable || decelDone);
      gainBoost <= fGain && !exclusiveAccess && mode_reg != MODE_TORQUE;
      gainValue <= (fGain && mode_reg != MODE_TORQUE) ? gain_reg : 16'h0;
      referenceSwitch <= fRef;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic outLevel(input logic [7:0] sel);
    logic v;
    v = 1'b0;
    case (sel)
      OF_READY: v = driveState != ST_FAULT;
      OF_POWERED: v = driveState == ST_OPENABLED;
      OF_ZSPEED: v = statusIn[0];
      OF_SPEED: v = statusIn[1];
      OF_MOVED: v = statusIn[2] && mode_reg == MODE_POSITION;
      OF_TORQUE: v = statusIn[3];
      OF_ERROR: v = driveState == ST_FAULT;
      OF_BRAKE: v = statusIn[4];
      OF_HOMED: v = statusIn[5];
      OF_OVERLOAD: v = statusIn[6];
      OF_ALERT: v = limitAlert || fStop;
      OF_OVERFLOW: v = statusIn[7];
      OF_SOFTNEG: v = statusIn[8];
      OF_SOFTPOS: v = statusIn[9];
      OF_CMDDONE: v = statusIn[10];
      OF_CAP1: v = statusIn[11];
      OF_CAP2: v = statusIn[12];
      default:
        if (sel >= OF_SW0 && sel <= OF_SW3)
          v = swWord_reg[sel[1:0]];
        else
          v = 1'b0;
    endcase
    return v;
  endfunction

  generate
    for (gi = 0; gi < NUM_OUT; gi++)
    begin : g_out
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
          digitalOutputTerminal[gi] <= 1'b0;
        else
          digitalOutputTerminal[gi] <= outLevel(outSel_reg[gi]);
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // every output is registered, so the checks look one edge ahead
  a_ready_fault: assert property (@(posedge clk) disable iff (!nrst)
    outSel_reg[0] == OF_READY && $stable(outSel_reg[0]) |=>
      digitalOutputTerminal[0] == ($past(driveState) != ST_FAULT))
    else $error("ready output does not follow fault state");
  a_powered_state: assert property (@(posedge clk) disable iff (!nrst)
    outSel_reg[1] == OF_POWERED && $stable(outSel_reg[1]) |=>
      digitalOutputTerminal[1] == ($past(driveState) == ST_OPENABLED))
    else $error("powered output wrong");
  a_dup_refused: assert property (@(posedge clk) disable iff (!nrst)
    inWr && !selOk |=> cfgErr_reg && inSel_reg[$past(inIdx)] == $past(inSel_reg[inIdx]))
    else $error("duplicate selector accepted");
  a_probe_place: assert property (@(posedge clk) disable iff (!nrst)
    inSel_reg[0] != FN_PROBE1 && inSel_reg[7] != FN_PROBE1 && inSel_reg[5] != FN_PROBE1)
    else $error("probe one on a wrong input");
  a_probe_two: assert property (@(posedge clk) disable iff (!nrst)
    inSel_reg[6] != FN_PROBE2 && inSel_reg[4] != FN_PROBE2 && inSel_reg[0] != FN_PROBE2)
    else $error("probe two on a wrong input");
  a_probe_pulse: assert property (@(posedge clk) disable iff (!nrst)
    probeTrigger[0] |=> !probeTrigger[0])
    else $error("probe trigger longer than one cycle");
  a_probe2_pulse: assert property (@(posedge clk) disable iff (!nrst)
    probeTrigger[1] |=> !probeTrigger[1])
    else $error("probe two trigger longer than one cycle");
  a_stop_order: assert property (@(posedge clk) disable iff (!nrst)
    $rose(powerDisable) |-> $past(decelDone) && $past(fStop) && decelRequest)
    else $error("power disabled before deceleration ended");
  a_limit_ramp: assert property (@(posedge clk) disable iff (!nrst)
    fNeg |=> limitAlert && decelRamp == $past(negRamp_reg))
    else $error("negative limit ramp not applied");
  a_limit_excl: assert property (@(posedge clk) disable iff (!nrst)
    exclusiveAccess && fPos |=> limitAlert && decelRequest)
    else $error("limit blocked by exclusive access");
  a_gain_mode: assert property (@(posedge clk) disable iff (!nrst)
    fGain && !exclusiveAccess && mode_reg != MODE_TORQUE |=> gainBoost)
    else $error("gain boost missing");
  a_unused_out: assert property (@(posedge clk) disable iff (!nrst)
    outSel_reg[2] == 8'h17 && $stable(outSel_reg[2]) |=> !digitalOutputTerminal[2])
    else $error("unused output code drives output");
  a_sw_bit: assert property (@(posedge clk) disable iff (!nrst)
    outSel_reg[3] == OF_SW3 && $stable(outSel_reg[3]) |=>
      digitalOutputTerminal[3] == $past(swWord_reg[3]))
    else $error("software bit not copied");
endmodule // drive_io_function_mapper

//--- verification/field_wiring.sv
// model of the field switches and sensors wired to the digital inputs
`timescale 1ns/1ps
module field_wiring (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] contactCmd,
  output logic [7:0] pinLevel
);
  // contacts settle one clock after the command; an open contact reads low
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pinLevel <= 8'h00;
    else
      pinLevel <= contactCmd;
  end
endmodule // field_wiring

//--- verification/test_drive_io_function_mapper.sv
// self-checking bench for the drive input/output function mapper
`timescale 1ns/1ps
module test_drive_io_function_mapper;
  import io_map_pkg::*;
  logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, contactCmd = 8'h00, pins;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, err, exclusiveAccess = 0, decelDone = 0;
  logic [3:0] driveState = ST_READY;
  logic [12:0] statusIn = 13'h0;
  logic [3:0] dout;
  logic [1:0] probeTrigger;
  logic decelRequest, powerDisable, limitAlert, gainBoost, referenceSwitch;
  logic [15:0] decelRamp, gainValue;
  int nMismatch = 0, totalChecks = 0, cycleCount = 0, p1Cnt = 0, p2Cnt = 0;
  logic [7:0] inReset [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h24, 8'h22, 8'h23, 8'h21};
  logic [7:0] outCode [13] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h10,
    8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h18};
  logic [7:0] deadCode [6] = '{8'h00, 8'h17, 8'h19, 8'h2f, 8'h34, 8'h3f};
  //////////////////////////////////////////////////////////////////////////////
  field_wiring wiring (.clk(clk), .nrst(nrst), .contactCmd(contactCmd), .pinLevel(pins));
  drive_io_function_mapper DUT (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .digitalInputTerminal(pins), .driveState(driveState),
    .exclusiveAccess(exclusiveAccess), .decelDone(decelDone), .statusIn(statusIn),
    .digitalOutputTerminal(dout), .probeTrigger(probeTrigger), .decelRequest(decelRequest),
    .decelRamp(decelRamp), .powerDisable(powerDisable), .limitAlert(limitAlert),
    .gainBoost(gainBoost), .gainValue(gainValue), .referenceSwitch(referenceSwitch));
  always #25 clk = ~clk;
  always @(posedge clk)
  begin
    p1Cnt <= p1Cnt + int'(probeTrigger[0] === 1'b1);
    p2Cnt <= p2Cnt + int'(probeTrigger[1] === 1'b1);
    cycleCount <= cycleCount + 1;
    if (cycleCount == 20000)
    begin
      nMismatch++;
      end_of_test();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task end_of_test();
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // request held until pready is seen high in the access cycle
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 20)
      chk("pready", 1, 0);
    rdata = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task rdChk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(0, a, 32'h0);
    chk(nm, exp, rdata);
  endtask
  // wiring edge, two sync edges, output edge, then two more for the pulse count
  task settle();
    repeat (6) @(posedge clk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge clk);
    nrst <= 1;
    for (int i = 0; i < 8; i++) rdChk("insel", 8'(4 * i), 32'(inReset[i]));
    rdChk("outsel1", 8'h20, 32'h01);
    chk("do1 ready", 1, dout[0]);
    apb(0, 8'h80, 0);
    chk("unmapped", 1, err);
    $display("test reset done");
    driveState <= ST_FAULT;
    settle();
    chk("do1 fault", 0, dout[0]);
    wr(8'h24, 32'h02);
    driveState <= ST_OPENABLED;
    settle();
    chk("do2 enabled", 1, dout[1]);
    driveState <= ST_SWITCHED;
    settle();
    chk("do2 switched", 0, dout[1]);
    for (int i = 0; i < 13; i++)
    begin
      wr(8'h28, 32'(outCode[i]));
      statusIn <= 13'h1 << i;
      settle();
      chk("do3 on", 1, dout[2]);
      statusIn <= ~(13'h1 << i);
      settle();
      chk("do3 off", 0, dout[2]);
    end
    wr(8'h28, 32'h07);
    driveState <= ST_FAULT;
    settle();
    chk("do3 error", 1, dout[2]);
    driveState <= ST_SWITCHED;
    settle();
    chk("do3 no error", 0, dout[2]);
    wr(8'h30, 32'hf);
    for (int i = 0; i < 6; i++)
    begin
      wr(8'h28, 32'(deadCode[i]));
      settle();
      chk("do3 unused", 0, dout[2]);
    end
    wr(8'h30, 32'h5);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h28, 32'h30 + 32'(i));
      settle();
      chk("do3 sw", 32'(~i & 1), dout[2]);
    end
    statusIn <= 13'h0;
    $display("test outputs done");
    wr(8'h00, 32'h1c);
    rdChk("probe1 elsewhere", 8'h00, 32'h0);
    rdChk("cfg error", 8'h48, 32'h100);
    wr(8'h48, 32'h100);
    wr(8'h18, 32'h1d);
    rdChk("probe2 elsewhere", 8'h18, 32'h23);
    wr(8'h00, 32'h21);
    rdChk("duplicate", 8'h00, 32'h0);
    wr(8'h18, 32'h1c);
    wr(8'h14, 32'h1d);
    rdChk("probe1 di7", 8'h18, 32'h1c);
    rdChk("probe2 di6", 8'h14, 32'h1d);
    contactCmd <= 8'h60;
    settle();
    chk("probe1 pulse", 1, p1Cnt);
    chk("probe2 pulse", 1, p2Cnt);
    contactCmd <= 8'h00;
    $display("test probes done");
    wr(8'h2c, 32'h11);
    contactCmd <= 8'h80;
    settle();
    chk("stop decel", 1, decelRequest);
    chk("stop ramp", 16'h0064, decelRamp);
    chk("stop early", 0, powerDisable);
    chk("alert stop", 1, dout[3]);
    decelDone <= 1;
    settle();
    chk("stop off", 1, powerDisable);
    contactCmd <= 8'h00;
    decelDone <= 0;
    settle();
    chk("stop release", 0, powerDisable);
    chk("alert clear", 0, dout[3]);
    wr(8'h14, 32'h22);
    wr(8'h18, 32'h23);
    wr(8'h38, 32'h0222);
    wr(8'h3c, 32'h0333);
    exclusiveAccess <= 1;
    contactCmd <= 8'h40;
    settle();
    chk("poslim alert", 1, limitAlert);
    chk("poslim ramp", 16'h0333, decelRamp);
    contactCmd <= 8'h20;
    settle();
    chk("neglim ramp", 16'h0222, decelRamp);
    contactCmd <= 8'h10;
    exclusiveAccess <= 0;
    settle();
    chk("limit clear", 0, limitAlert);
    chk("reference", 1, referenceSwitch);
    $display("test stops done");
    wr(8'h00, 32'h03);
    wr(8'h40, 32'h1234);
    contactCmd <= 8'h01;
    settle();
    chk("gain on", 1, gainBoost);
    chk("gain value", 16'h1234, gainValue);
    wr(8'h44, 32'h2);
    settle();
    chk("gain torque", 0, gainBoost);
    $display("test gain done");
    end_of_test();
  end
endmodule // test_drive_io_function_mapper
